// ---- rtl/tcf_pkg.sv ----
// Constants and register map of the timer capture and edge input block
package tcf_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL       = 8'h00;
  localparam logic [7:0] OFS_PRESCALE   = 8'h04;
  localparam logic [7:0] OFS_EDGE       = 8'h08;
  localparam logic [7:0] OFS_COUNT      = 8'h0c;
  localparam logic [7:0] OFS_CAP_FIRST  = 8'h10;
  localparam logic [7:0] OFS_CAP_SECOND = 8'h14;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK   = 8'h1c;
  // Control register fields
  localparam int CTRL_RUN_BIT        = 0;
  localparam int CTRL_SRC_PIN_A_BIT  = 1;
  localparam int CTRL_CMP_FIRST_BIT  = 2;
  localparam int CTRL_CMP_SECOND_BIT = 3;
  // Edge register fields
  localparam int EDGE_A_LSB = 0;
  localparam int EDGE_B_LSB = 2;
  localparam int EDGE_W     = 2;
  // Valid edge encodings
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_NONE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Prescaler select width and width of the prescaler divider counter
  localparam int PSC_W       = 2;
  localparam int DIV_W       = 5;
  // Reset values
  localparam logic [1:0]  RST_PSC    = 2'h0;
  localparam logic [1:0]  RST_EDGE   = 2'h1;
  localparam logic [15:0] RST_CAP    = 16'h0000;
  localparam logic [1:0]  RST_MASK   = 2'h0;
  // Interrupt status bits
  localparam int IRQ_FIRST_BIT  = 0;
  localparam int IRQ_SECOND_BIT = 1;
  localparam int IRQ_W          = 2;
endpackage

// ---- rtl/tcf_filt_if.sv ----
// Signals between the control logic and one input noise filter
`timescale 1ns/1ps
interface tcf_filt_if;
  logic       pin;
  logic       sample_en;
  logic       run;
  logic       run_start;
  logic       first_run;
  logic [1:0] edge_sel;
  logic       edge_pulse;

  // Filter side
  modport filt
  (
    input  pin,
    input  sample_en,
    input  run,
    input  run_start,
    input  first_run,
    input  edge_sel,
    output edge_pulse
  );
  // Control side
  modport ctrl
  (
    output pin,
    output sample_en,
    output run,
    output run_start,
    output first_run,
    output edge_sel,
    input  edge_pulse
  );
endinterface

// ---- rtl/tcf_filter.sv ----
// Two-sample noise filter and valid edge detector for one timer input
`timescale 1ns/1ps
module tcf_filter
  import tcf_pkg::*;
(
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Control link
  tcf_filt_if.filt  fi
);

  logic sample_ff;
  logic level_ff;
  logic edge_ff;
  logic nxt_level;

  // Level accepted after two equal consecutive samples
  always_comb
  begin
    nxt_level = level_ff;
    if (fi.sample_en && (fi.pin == sample_ff))
    begin
      nxt_level = fi.pin;
    end
  end

  // Sample and filtered level; reloaded at each start of operation
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sample_ff <= 1'b0;
      level_ff  <= 1'b0;
    end
    else if (fi.run_start)
    begin
      // First start after reset sees a high pin as a rising edge
      sample_ff <= fi.first_run ? 1'b0 : fi.pin;
      level_ff  <= fi.first_run ? 1'b0 : fi.pin;
    end
    else if (fi.run)
    begin
      if (fi.sample_en)
      begin
        sample_ff <= fi.pin;
      end
      level_ff <= nxt_level;
    end
  end

  // Valid edge pulse, suppressed while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      edge_ff <= 1'b0;
    end
    else
    begin
      edge_ff <= 1'b0;
      if (fi.run && !fi.run_start && (nxt_level != level_ff))
      begin
        unique case (fi.edge_sel)
          EDGE_FALL: edge_ff <= !nxt_level;
          EDGE_RISE: edge_ff <= nxt_level;
          EDGE_NONE: edge_ff <= 1'b0;
          EDGE_BOTH: edge_ff <= 1'b1;
        endcase
      end
    end
  end

  assign fi.edge_pulse = edge_ff;

endmodule

// ---- rtl/tcf_capture.sv ----
// Timer counter with capture/compare registers, input filters and APB slave
//
// Local design decisions: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ps
module tcf_capture
  import tcf_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16
)
(
  // Clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // APB slave
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // Timer input pins
  input  wire logic              count_capture_pin_a,
  input  wire logic              capture_pin_b,
  // Interrupts
  output logic                   irq,
  output logic                   capture_irq_first,
  output logic                   capture_irq_second
);

  // Elaboration checks
  if ((ADDR_W < 8) || (ADDR_W > 32))
  begin : g_chk_addr
    $error("ADDR_W must be 8 to 32");
  end
  if ((CNT_W < 1) || (CNT_W > 32))
  begin : g_chk_cnt
    $error("CNT_W must be 1 to 32");
  end

  // Count clock period in system clocks for a prescaler select
  function automatic logic [DIV_W-1:0] psc_period(input logic [PSC_W-1:0] sel);
    psc_period = DIV_W'(2) << sel;
  endfunction

  // Full byte address match against a register offset
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs)); // Upper address bits must be zero
  endfunction

  logic              pa_s1_ff;
  logic              pa_s2_ff;
  logic              pb_s1_ff;
  logic              pb_s2_ff;
  logic              run_ff;
  logic              run_d_ff;
  logic              ran_once_ff;
  logic              src_a_ff;
  logic              cmp_first_ff;
  logic              cmp_second_ff;
  logic [PSC_W-1:0]  psc_ff;
  logic [1:0]        edge_a_ff;
  logic [1:0]        edge_b_ff;
  logic [DIV_W-1:0]  div_ff;
  logic [CNT_W-1:0]  count_ff;
  logic [CNT_W-1:0]  cap_first_ff;
  logic [CNT_W-1:0]  cap_second_ff;
  logic [1:0]        pend_cap_ff;
  logic [1:0]        pend_irq_ff;
  logic [IRQ_W-1:0]  sts_ff;
  logic [IRQ_W-1:0]  mask_ff;
  logic [31:0]       prdata_ff;
  logic              pready_ff;
  logic              pslverr_ff;
  logic              irq_ff;
  logic              irq_first_ff;
  logic              irq_second_ff;
  logic [DIV_W-1:0]  period;
  logic              rise_tick;
  logic              fall_tick;
  logic              run_start;
  logic              cnt_tick;
  logic              acc;
  logic              wr_en;
  logic              mapped;
  logic [1:0]        trig;
  logic [IRQ_W-1:0]  evt;
  logic [IRQ_W-1:0]  nxt_sts;
  logic [31:0]       nxt_rdata;

  tcf_filt_if fa ();
  tcf_filt_if fb ();

  // Two-flop synchronisers for the input pins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pa_s1_ff <= 1'b0;
      pa_s2_ff <= 1'b0;
      pb_s1_ff <= 1'b0;
      pb_s2_ff <= 1'b0;
    end
    else
    begin
      pa_s1_ff <= count_capture_pin_a;
      pa_s2_ff <= pa_s1_ff;
      pb_s1_ff <= capture_pin_b;
      pb_s2_ff <= pb_s1_ff;
    end
  end

  // Bus access decode; one wait state on every access
  assign acc       = psel && penable && pready_ff;
  assign wr_en     = acc && pwrite;
  assign run_start = run_ff && !run_d_ff;

  // Count clock ticks from the prescaler
  assign period    = psc_period(psc_ff);
  assign rise_tick = run_ff && (div_ff == (period - DIV_W'(1)));
  assign fall_tick = run_ff && (div_ff == ((period >> 1) - DIV_W'(1)));

  // Filter hookup; pin A samples on system clock when it is the count clock
  assign fa.pin       = pa_s2_ff;
  assign fa.sample_en = src_a_ff ? 1'b1 : rise_tick;
  assign fa.run       = run_ff;
  assign fa.run_start = run_start;
  assign fa.first_run = !ran_once_ff;
  assign fa.edge_sel  = edge_a_ff;
  assign fb.pin       = pb_s2_ff;
  assign fb.sample_en = rise_tick;
  assign fb.run       = run_ff;
  assign fb.run_start = run_start;
  assign fb.first_run = !ran_once_ff;
  assign fb.edge_sel  = edge_b_ff;

  tcf_filter u_filt_a
  (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (fa)
  );

  tcf_filter u_filt_b
  (
    .pclk    (pclk),
    .presetn (presetn),
    .fi      (fb)
  );

  // Capture triggers; none from pin A while it clocks the counter
  assign trig[0]  = fa.edge_pulse && !src_a_ff && !cmp_first_ff;
  assign trig[1]  = fb.edge_pulse && !cmp_second_ff;
  assign cnt_tick = run_ff && (src_a_ff ? fa.edge_pulse : rise_tick);

  // Control and configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_ff        <= 1'b0;
      src_a_ff      <= 1'b0;
      cmp_first_ff  <= 1'b0;
      cmp_second_ff <= 1'b0;
      psc_ff        <= RST_PSC;
      edge_a_ff     <= RST_EDGE;
      edge_b_ff     <= RST_EDGE;
      mask_ff       <= RST_MASK;
    end
    else if (wr_en)
    begin
      if (hit(paddr, OFS_CTRL))
      begin
        run_ff        <= pwdata[CTRL_RUN_BIT];
        src_a_ff      <= pwdata[CTRL_SRC_PIN_A_BIT];
        cmp_first_ff  <= pwdata[CTRL_CMP_FIRST_BIT];
        cmp_second_ff <= pwdata[CTRL_CMP_SECOND_BIT];
      end
      if (hit(paddr, OFS_PRESCALE))
      begin
        psc_ff <= pwdata[PSC_W-1:0];
      end
      if (hit(paddr, OFS_EDGE))
      begin
        edge_a_ff <= pwdata[EDGE_A_LSB +: EDGE_W];
        edge_b_ff <= pwdata[EDGE_B_LSB +: EDGE_W];
      end
      if (hit(paddr, OFS_IRQ_MASK))
      begin
        mask_ff <= pwdata[IRQ_W-1:0];
      end
    end
  end

  // Start detection and first-run memory
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_d_ff    <= 1'b0;
      ran_once_ff <= 1'b0;
    end
    else
    begin
      run_d_ff <= run_ff;
      if (run_start)
      begin
        ran_once_ff <= 1'b1;
      end
    end
  end

  // Prescaler divider, held at zero while stopped
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_ff <= '0;
    end
    else if (!run_ff || rise_tick || (div_ff >= (period - DIV_W'(1))))
    begin
      div_ff <= '0;
    end
    else
    begin
      div_ff <= div_ff + DIV_W'(1);
    end
  end

  // Counter; cleared on each start
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_ff <= '0;
    end
    else if (run_start)
    begin
      count_ff <= '0;
    end
    else if (cnt_tick)
    begin
      count_ff <= count_ff + CNT_W'(1);
    end
  end

  // Pending capture until the count clock falls, then pending interrupt until it rises
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pend_cap_ff <= 2'h0;
      pend_irq_ff <= 2'h0;
    end
    else
    begin
      pend_cap_ff <= (pend_cap_ff & ~{2{fall_tick}}) | trig;
      pend_irq_ff <= (pend_irq_ff & ~{2{rise_tick}}) | (pend_cap_ff & {2{fall_tick}});
    end
  end

  // Capture registers; capture beats a software write in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cap_first_ff  <= CNT_W'(RST_CAP);
      cap_second_ff <= CNT_W'(RST_CAP);
    end
    else
    begin
      if (fall_tick && pend_cap_ff[0])
      begin
        cap_first_ff <= count_ff;
      end
      else if (wr_en && hit(paddr, OFS_CAP_FIRST))
      begin
        cap_first_ff <= pwdata[CNT_W-1:0];
      end
      if (fall_tick && pend_cap_ff[1])
      begin
        cap_second_ff <= count_ff;
      end
      else if (wr_en && hit(paddr, OFS_CAP_SECOND))
      begin
        cap_second_ff <= pwdata[CNT_W-1:0];
      end
    end
  end

  // Events: capture at count-clock rise, or compare match in compare mode
  assign evt[IRQ_FIRST_BIT]  = (rise_tick && pend_irq_ff[0]) ||
                               (cnt_tick && cmp_first_ff && ((count_ff + CNT_W'(1)) == cap_first_ff));
  assign evt[IRQ_SECOND_BIT] = (rise_tick && pend_irq_ff[1]) ||
                               (cnt_tick && cmp_second_ff && ((count_ff + CNT_W'(1)) == cap_second_ff));

  // Sticky status, write one to clear; a new event wins over the clear
  always_comb
  begin
    nxt_sts = sts_ff;
    if (wr_en && hit(paddr, OFS_IRQ_STATUS))
    begin
      nxt_sts = sts_ff & ~pwdata[IRQ_W-1:0];
    end
    nxt_sts = nxt_sts | evt;
  end

  // Status and interrupt outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sts_ff        <= '0;
      irq_ff        <= 1'b0;
      irq_first_ff  <= 1'b0;
      irq_second_ff <= 1'b0;
    end
    else
    begin
      sts_ff        <= nxt_sts;
      irq_ff        <= |(nxt_sts & mask_ff);
      irq_first_ff  <= evt[IRQ_FIRST_BIT];
      irq_second_ff <= evt[IRQ_SECOND_BIT];
    end
  end

  // Read data multiplexer
  always_comb
  begin
    nxt_rdata = 32'h0000_0000;
    mapped    = 1'b1;
    if (hit(paddr, OFS_CTRL))
    begin
      nxt_rdata[CTRL_RUN_BIT]        = run_ff;
      nxt_rdata[CTRL_SRC_PIN_A_BIT]  = src_a_ff;
      nxt_rdata[CTRL_CMP_FIRST_BIT]  = cmp_first_ff;
      nxt_rdata[CTRL_CMP_SECOND_BIT] = cmp_second_ff;
    end
    else if (hit(paddr, OFS_PRESCALE))
    begin
      nxt_rdata[PSC_W-1:0] = psc_ff;
    end
    else if (hit(paddr, OFS_EDGE))
    begin
      nxt_rdata[EDGE_A_LSB +: EDGE_W] = edge_a_ff;
      nxt_rdata[EDGE_B_LSB +: EDGE_W] = edge_b_ff;
    end
    else if (hit(paddr, OFS_COUNT))
    begin
      nxt_rdata[CNT_W-1:0] = count_ff;
    end
    else if (hit(paddr, OFS_CAP_FIRST))
    begin
      nxt_rdata[CNT_W-1:0] = cap_first_ff;
    end
    else if (hit(paddr, OFS_CAP_SECOND))
    begin
      nxt_rdata[CNT_W-1:0] = cap_second_ff;
    end
    else if (hit(paddr, OFS_IRQ_STATUS))
    begin
      nxt_rdata[IRQ_W-1:0] = sts_ff;
    end
    else if (hit(paddr, OFS_IRQ_MASK))
    begin
      nxt_rdata[IRQ_W-1:0] = mask_ff;
    end
    else
    begin
      mapped = 1'b0;
    end
  end

  // APB answer: ready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= psel && penable && !pready_ff;
      pslverr_ff <= psel && penable && !pready_ff && !mapped;
      if (psel && penable && !pready_ff && !pwrite)
      begin
        prdata_ff <= nxt_rdata;
      end
    end
  end

  assign prdata             = prdata_ff;
  assign pready             = pready_ff;
  assign pslverr            = pslverr_ff;
  assign irq                = irq_ff;
  assign capture_irq_first  = irq_first_ff;
  assign capture_irq_second = irq_second_ff;

endmodule

// ---- verif/tcf_pin_src.sv ----
// Model of the external pulse sources on the two timer pins
`timescale 1ns/1ps
module tcf_pin_src
(
  // Clock
  input  wire logic pclk,
  // Timer pins
  output logic      pin_a,
  output logic      pin_b
);
  // Pin B starts high, as if pulled up through reset
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b1;
  end

  // Invert one pin just after a clock edge
  task automatic flip(input logic sel_b);
    @(posedge pclk);
    if (sel_b)
      pin_b <= ~pin_b;
    else
      pin_a <= ~pin_a;
  endtask

  // Invert one pin, hold it for len clocks, then restore it
  task automatic pulse(input logic sel_b, input int len);
    flip(sel_b);
    repeat (len - 1) @(posedge pclk);
    flip(sel_b);
  endtask
endmodule

// ---- verif/tcf_capture_sva.sv ----
// Port checker of the timer capture block
`timescale 1ns/1ps
module tcf_capture_sva
  import tcf_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int CNT_W  = 16
)
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [31:0]       pwdata,
  input wire logic [31:0]       prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              count_capture_pin_a,
  input wire logic              capture_pin_b,
  input wire logic              irq,
  input wire logic              capture_irq_first,
  input wire logic              capture_irq_second
);
  logic       wr_done;
  logic [3:0] ctrl_ff;
  logic [5:0] age_ff;

  // Completed write and shadow of the control register
  assign wr_done = psel && penable && pready && pwrite;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      ctrl_ff <= 4'h0;
    else if (wr_done && paddr == OFS_CTRL)
      ctrl_ff <= pwdata[3:0];

  // Clocks since the last control write, saturating
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      age_ff <= 6'h00;
    else if (wr_done && paddr == OFS_CTRL)
      age_ff <= 6'h00;
    else if (age_ff != 6'h3f)
      age_ff <= age_ff + 6'h01;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_ready_wait;
    psel && penable && !$past(penable) |-> !pready ##1 pready;
  endproperty
  a_ready_wait: assert property (p_ready_wait) else $error("pready not after one wait state");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready longer than one cycle");
  property p_err_decode;
    pready |-> psel && penable && (pslverr == (paddr > 8'h1c));
  endproperty
  a_err_decode: assert property (p_err_decode) else $error("pslverr does not match address");
  property p_stopped_quiet;
    !ctrl_ff[CTRL_RUN_BIT] && age_ff == 6'h3f |-> !capture_irq_first && !capture_irq_second;
  endproperty
  a_stopped_quiet: assert property (p_stopped_quiet) else $error("event while stopped");
  property p_pin_clock_no_cap;
    ctrl_ff[CTRL_RUN_BIT] && ctrl_ff[CTRL_SRC_PIN_A_BIT] && !ctrl_ff[CTRL_CMP_FIRST_BIT] && age_ff == 6'h3f
      |-> !capture_irq_first;
  endproperty
  a_pin_clock_no_cap: assert property (p_pin_clock_no_cap) else $error("capture by clock pin");
  property p_pulse_first;
    capture_irq_first |=> !capture_irq_first;
  endproperty
  a_pulse_first: assert property (p_pulse_first) else $error("first event too long");
  property p_pulse_second;
    capture_irq_second |=> !capture_irq_second;
  endproperty
  a_pulse_second: assert property (p_pulse_second) else $error("second event too long");
  property p_irq_cause;
    $rose(irq) |-> capture_irq_first || capture_irq_second || $past(capture_irq_first || capture_irq_second)
      || $past(wr_done) || $past(wr_done, 2);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq rose without cause");
  property p_mask_off;
    wr_done && paddr == OFS_IRQ_MASK && pwdata[1:0] == 2'h0 |-> ##2 !irq;
  endproperty
  a_mask_off: assert property (p_mask_off) else $error("irq high while masked");

  c_second: cover property (capture_irq_second);
  c_err: cover property (pready && pslverr);
  c_irq: cover property ($rose(irq));
endmodule

bind tcf_capture tcf_capture_sva #(.ADDR_W(ADDR_W), .CNT_W(CNT_W)) tcf_capture_sva_i
(
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .count_capture_pin_a(count_capture_pin_a), .capture_pin_b(capture_pin_b), .irq(irq),
  .capture_irq_first(capture_irq_first), .capture_irq_second(capture_irq_second)
);

// ---- verif/tcf_capture_tb_top.sv ----
// Self-checking testbench of the timer capture block
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
  $display("Error %s expected %0h seen %0h", nm, e, g); end end
module tcf_capture_tb_top
  import tcf_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic [7:0]  paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pin_a;
  logic        pin_b;
  logic        irq;
  logic        ev_first;
  logic        ev_second;
  int          n_errors;
  int          n_compared;
  logic [7:0]  seed;
  logic [31:0] q;
  logic [31:0] prev;
  logic        hit;
  logic        e;

  tcf_capture tcf_capture_i
  (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .count_capture_pin_a(pin_a),
    .capture_pin_b(pin_b), .irq(irq), .capture_irq_first(ev_first), .capture_irq_second(ev_second)
  );
  tcf_pin_src tcf_pin_src_i (.pclk(pclk), .pin_a(pin_a), .pin_b(pin_b));

  // Clock at 250 MHz
  initial
  begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  // Next value of the stimulus shift register
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // One APB transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rq,
                     output logic re);
    int n;
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
      n_errors++;
    rq = prdata;
    re = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  // Read and compare one register
  task automatic chk_rd(input string nm, input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, q, e);
    `CHK(nm, x, q)
  endtask

  // Watch one event output for n clocks
  task automatic wait_ev(input logic sel_b, input int n, output logic h);
    h = 1'b0;
    repeat (n)
    begin
      @(posedge pclk);
      if ((sel_b ? ev_second : ev_first) === 1'b1)
        h = 1'b1;
    end
  endtask

  task automatic tally_and_finish;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (40000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end

  // Main sequence
  initial
  begin
    n_errors = 0;
    n_compared = 0;
    seed = 8'h22;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    chk_rd("prescale", OFS_PRESCALE, {30'h0, RST_PSC});
    chk_rd("mask", OFS_IRQ_MASK, {30'h0, RST_MASK});
    chk_rd("unmapped", 8'h20, 32'h0);
    `CHK("slverr", 1'b1, e)
    $display("test reset done");
    wr(OFS_EDGE, {28'h0, EDGE_RISE, EDGE_RISE});
    wr(OFS_IRQ_MASK, 32'h3);
    fork
      wr(OFS_CTRL, 32'h1);
      wait_ev(1'b1, 120, hit);
    join
    `CHK("first start edge", 1'b1, hit)
    `CHK("irq", 1'b1, irq)
    chk_rd("status", OFS_IRQ_STATUS, 32'h2);
    wr(OFS_IRQ_STATUS, 32'h2);
    chk_rd("status clr", OFS_IRQ_STATUS, 32'h0);
    $display("test first start done");
    wr(OFS_CTRL, 32'h0);
    fork
      tcf_pin_src_i.pulse(1'b1, 30);
      wait_ev(1'b1, 80, hit);
    join
    `CHK("stopped", 1'b0, hit)
    fork
      wr(OFS_CTRL, 32'h1);
      wait_ev(1'b1, 100, hit);
    join
    `CHK("restart edge", 1'b0, hit)
    tcf_pin_src_i.flip(1'b1);
    wait_ev(1'b1, 30, hit);
    fork
      tcf_pin_src_i.pulse(1'b1, 1);
      wait_ev(1'b1, 60, hit);
    join
    `CHK("glitch", 1'b0, hit)
    $display("test stop and noise done");
    apb(1'b0, OFS_CAP_SECOND, 32'h0, prev, e);
    for (int k = 0; k < 4; k++)
    begin
      seed = lfsr_next(seed);
      fork
        tcf_pin_src_i.pulse(1'b1, 10 + int'(seed[3:0]));
        wait_ev(1'b1, 60, hit);
      join
      `CHK("capture event", 1'b1, hit)
      chk_rd("status", OFS_IRQ_STATUS, 32'h2);
      apb(1'b0, OFS_CAP_SECOND, 32'h0, q, e);
      `CHK("cap grows", 1'b1, q[15:0] > prev[15:0])
      prev = q;
      wait_ev(1'b1, 20 + int'(seed[7:4]), hit);
      chk_rd("cap held", OFS_CAP_SECOND, prev);
      wr(OFS_IRQ_STATUS, 32'h2);
    end
    fork
      tcf_pin_src_i.pulse(1'b1, 12);
      wait_ev(1'b1, 60, hit);
    join
    `CHK("irq set", 1'b1, irq)
    wr(OFS_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    `CHK("masked irq", 1'b0, irq)
    apb(1'b0, OFS_CAP_SECOND, 32'h0, prev, e);
    $display("test random capture done");
    wr(OFS_CTRL, 32'h9);
    tcf_pin_src_i.pulse(1'b1, 12);
    wait_ev(1'b1, 40, hit);
    chk_rd("compare mode", OFS_CAP_SECOND, prev);
    wr(OFS_CTRL, 32'h0);
    apb(1'b0, OFS_CAP_FIRST, 32'h0, prev, e);
    wr(OFS_EDGE, {28'h0, EDGE_NONE, EDGE_RISE});
    wr(OFS_CTRL, 32'h3);
    for (int k = 0; k < 5; k++)
    begin
      tcf_pin_src_i.pulse(1'b0, 4);
      repeat (4) @(posedge pclk);
    end
    chk_rd("pin count", OFS_COUNT, 32'h5);
    chk_rd("pin no cap", OFS_CAP_FIRST, prev);
    $display("test pin clock done");
    tally_and_finish();
  end
endmodule
